// *** design/cda_alu_map.svh ***
// Constants for the complement and decimal-adjust datapath.
`ifndef CDA_ALU_MAP_SVH
`define CDA_ALU_MAP_SVH
`define CDA_NIBBLE_MAX 4'h9
`define CDA_NIBBLE_FIX 4'h6
`define CDA_ADJ_NONE 8'h00
`define CDA_ADJ_LOW 8'h06
`define CDA_ADJ_HIGH 8'h60
`define CDA_ADJ_BOTH 8'h66
`define CDA_ACC_RESET 8'h00
`define CDA_FLAG_RESET 1'b0
`endif

// *** design/cda_alu_pkg.sv ***
// Types for the complement and decimal-adjust datapath.
package cda_alu_pkg;
  // Operation select, one-hot so the decoder can drive it directly.
  typedef enum logic [3:0] {
    CDA_OP_NONE = 4'h1,
    CDA_OP_COMPLEMENT_MEMORY = 4'h2,
    CDA_OP_COMPLEMENT_TO_ACC = 4'h4,
    CDA_OP_DECIMAL_ADJUST = 4'h8
  } cda_op_t;
endpackage

// *** design/cda_adjust.sv ***
// Combinational decimal-correction constant selector and adder.
`timescale 1ns/1ps
`default_nettype none
`include "cda_alu_map.svh"
module cda_adjust #(
  parameter int WIDTH = 8
) (
  // Operand and flags.
  input wire logic [WIDTH-1:0] acc_in,
  input wire logic half_carry_in,
  input wire logic carry_in,
  // Corrected byte and carry.
  output logic [WIDTH-1:0] result,
  output logic carry_out
);
  // The nibble tests below are fixed at four bits, so only a byte can be served.
  if (WIDTH != 8) begin : g_width_check
    $error("cda_adjust supports an 8-bit byte only");
  end

  logic low_fix;
  logic high_fix;
  logic [WIDTH:0] sum;
  logic [WIDTH-1:0] adj;

  // The high nibble is judged as it stands after the low correction: a 9 that takes the
  // low carry becomes ten and needs its 6 too, else a BCD sum of 100 loses its carry.
  always_comb begin
    low_fix = (acc_in[3:0] > `CDA_NIBBLE_MAX) || half_carry_in;
    high_fix = (acc_in[7:4] > `CDA_NIBBLE_MAX) || carry_in
      || ((acc_in[7:4] == `CDA_NIBBLE_MAX) && (acc_in[3:0] > `CDA_NIBBLE_MAX));
    if (low_fix && high_fix) begin
      adj = `CDA_ADJ_BOTH;
    end else if (high_fix) begin
      adj = `CDA_ADJ_HIGH;
    end else if (low_fix) begin
      adj = `CDA_ADJ_LOW;
    end else begin
      adj = `CDA_ADJ_NONE;
    end
    sum = {1'b0, acc_in} + {1'b0, adj};
    result = sum[WIDTH-1:0];
    carry_out = carry_in || sum[WIDTH];
  end
endmodule
`default_nettype wire

// *** design/cda_alu.sv ***
// Complement and decimal-adjust ALU slice with accumulator and flags.
//
// Overview of operation
// - Complement memory byte in place, update zero.
// - Complemented byte to accumulator, memory untouched, zero.
// - Decimal adjust accumulator, result written to memory.
// - Low nibble over 9 or half-carry: add 6.
// - High nibble over 9 or carry: add 6.
// - Correction adds 00H, 06H, 60H or 66H.
// - Adjust touches only carry; carry set past 99.
`timescale 1ns/1ps
`default_nettype none
`include "cda_alu_map.svh"
module cda_alu
  import cda_alu_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock, reset and enable.
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // Instruction from the decoder, one cycle per valid strobe.
  input wire logic OP_VALID,
  input wire cda_alu_pkg::cda_op_t OP_SEL,
  input wire logic [WIDTH-1:0] MEM_RDATA,
  // Flag and accumulator loads from the rest of the core.
  input wire logic FLAG_LOAD,
  input wire logic HALF_CARRY_IN,
  input wire logic CARRY_IN,
  input wire logic ACC_LOAD,
  input wire logic [WIDTH-1:0] ACC_IN,
  // Memory write-back.
  output logic MEM_WE,
  output logic [WIDTH-1:0] MEM_WDATA,
  // Architectural state.
  output logic [WIDTH-1:0] ACCUMULATOR_REG,
  output logic ZERO_FLAG,
  output logic CARRY_FLAG,
  output logic HALF_CARRY_FLAG
);
  import cda_alu_pkg::*;

  // The slice is byte-wide throughout; refuse any other width when elaborating.
  if (WIDTH != 8) begin : g_width_check
    $error("cda_alu supports an 8-bit byte only");
  end

  // Zero test of a result byte, shared by both complement paths.
  function automatic logic byte_is_zero(input logic [WIDTH-1:0] value);
    return (value == '0);
  endfunction

  logic [WIDTH-1:0] acc_q, acc_d, wdata_q, wdata_d;
  logic we_q, we_d, z_q, z_d, c_q, c_d, half_q, half_d;
  logic [WIDTH-1:0] adj_result;
  logic adj_carry;
  logic [WIDTH-1:0] inv;

  // The adjuster reads registered state only, so a load in the same cycle cannot race it.
  cda_adjust #(.WIDTH(WIDTH)) u_adjust (
    .acc_in(acc_q),
    .half_carry_in(half_q),
    .carry_in(c_q),
    .result(adj_result),
    .carry_out(adj_carry)
  );

  // Next-state for accumulator, flags and the write strobe.
  // Plain loads come first and an operation result last, so the operation wins a clash.
  always_comb begin
    inv = ~MEM_RDATA;
    acc_d = acc_q;
    wdata_d = wdata_q;
    we_d = 1'b0;
    z_d = z_q;
    c_d = c_q;
    half_d = half_q;
    if (ACC_LOAD) begin
      acc_d = ACC_IN;
    end
    if (FLAG_LOAD) begin
      c_d = CARRY_IN;
      half_d = HALF_CARRY_IN;
    end
    if (OP_VALID) begin
      unique case (OP_SEL)
        CDA_OP_COMPLEMENT_MEMORY: begin
          wdata_d = inv;
          we_d = 1'b1;
          z_d = byte_is_zero(inv);
        end
        CDA_OP_COMPLEMENT_TO_ACC: begin
          acc_d = inv;
          z_d = byte_is_zero(inv);
        end
        CDA_OP_DECIMAL_ADJUST: begin
          // The accumulator and the zero flag are left alone; only carry may move.
          wdata_d = adj_result;
          we_d = 1'b1;
          c_d = adj_carry;
        end
        CDA_OP_NONE: begin
        end
        // A code that is not one-hot is ignored rather than half decoded.
        default: begin
        end
      endcase
    end
  end

  // State registers; the enable freezes everything, write strobe included.
  // A strobe caught by a low enable stays high until the next enabled edge, so the
  // memory side must qualify it with the same enable to avoid a double write.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      acc_q <= `CDA_ACC_RESET;
      wdata_q <= '0;
      we_q <= 1'b0;
      z_q <= `CDA_FLAG_RESET;
      c_q <= `CDA_FLAG_RESET;
      half_q <= `CDA_FLAG_RESET;
    end else if (CLK_EN) begin
      acc_q <= acc_d;
      wdata_q <= wdata_d;
      we_q <= we_d;
      z_q <= z_d;
      c_q <= c_d;
      half_q <= half_d;
    end
  end

  // Outputs come straight from the registers, so no input reaches them combinationally.
  assign MEM_WE = we_q;
  assign MEM_WDATA = wdata_q;
  assign ACCUMULATOR_REG = acc_q;
  assign ZERO_FLAG = z_q;
  assign CARRY_FLAG = c_q;
  assign HALF_CARRY_FLAG = half_q;

  // Checks of each operation against its cause one cycle earlier.
  sequence s_op(cda_op_t o);
    CLK_EN && OP_VALID && OP_SEL == o;
  endsequence

  // An enabled edge that carries no operation.
  sequence s_no_op;
    CLK_EN && !OP_VALID;
  endsequence

  // Decimal adjust taken while the low nibble needs no correction.
  sequence s_adjust_low_clean;
    s_op(CDA_OP_DECIMAL_ADJUST) ##0 (acc_q[3:0] <= `CDA_NIBBLE_MAX && !half_q);
  endsequence

  // The inverted byte goes back to memory and sets zero from itself.
  a_invert_mem_write: assert property (@(posedge MCLK) disable iff (SYS_RST)
    s_op(CDA_OP_COMPLEMENT_MEMORY) |=> MEM_WE && MEM_WDATA == ~$past(MEM_RDATA)
      && ZERO_FLAG == ($past(MEM_RDATA) == 8'hFF))
    else $error("complement memory result wrong");

  // The inverted byte lands in the accumulator even against a plain load.
  a_invert_acc_load: assert property (@(posedge MCLK) disable iff (SYS_RST)
    s_op(CDA_OP_COMPLEMENT_TO_ACC) |=> !MEM_WE
      && ACCUMULATOR_REG == ~$past(MEM_RDATA))
    else $error("complement to accumulator wrong");

  // Zero follows the accumulator result, not the memory byte.
  a_invert_acc_zero: assert property (@(posedge MCLK) disable iff (SYS_RST)
    s_op(CDA_OP_COMPLEMENT_TO_ACC) |=> ZERO_FLAG == ($past(MEM_RDATA) == 8'hFF))
    else $error("complement to accumulator zero wrong");

  // Every adjust writes its result back to memory.
  a_adjust_mem_write: assert property (@(posedge MCLK) disable iff (SYS_RST)
    s_op(CDA_OP_DECIMAL_ADJUST) |=> MEM_WE)
    else $error("decimal adjust did not write memory");

  // A clean low nibble passes through untouched.
  a_adjust_low_fix: assert property (@(posedge MCLK) disable iff (SYS_RST)
    s_adjust_low_clean |=> MEM_WDATA[3:0] == $past(acc_q[3:0]))
    else $error("low nibble changed without cause");

  // Carry alone forces the high correction.
  a_adjust_high_fix: assert property (@(posedge MCLK) disable iff (SYS_RST)
    s_adjust_low_clean ##0 c_q |=> MEM_WDATA == $past(acc_q) + 8'h60)
    else $error("high nibble not corrected");

  // Both flags together select the full correction constant.
  a_adjust_both_fix: assert property (@(posedge MCLK) disable iff (SYS_RST)
    s_op(CDA_OP_DECIMAL_ADJUST) ##0 (c_q && half_q) |=> MEM_WDATA == $past(acc_q) + 8'h66)
    else $error("both-nibble correction wrong");

  // Only carry may move; a carry already set is never cleared.
  a_adjust_flags_kept: assert property (@(posedge MCLK) disable iff (SYS_RST)
    s_op(CDA_OP_DECIMAL_ADJUST) ##0 (!FLAG_LOAD && !ACC_LOAD) |=> $stable(ZERO_FLAG)
      && $stable(HALF_CARRY_FLAG) && $stable(ACCUMULATOR_REG) && (CARRY_FLAG || !$past(c_q)))
    else $error("decimal adjust disturbed a flag");

  // A byte past 99H is a decimal overflow and must carry into the next byte.
  a_adjust_carry_set: assert property (@(posedge MCLK) disable iff (SYS_RST)
    s_op(CDA_OP_DECIMAL_ADJUST) ##0 (acc_q > 8'h99) |=> CARRY_FLAG)
    else $error("decimal adjust lost the decimal carry");

  // The write strobe never rises after an enabled edge that carries no operation.
  a_idle_no_write: assert property (@(posedge MCLK) disable iff (SYS_RST)
    s_no_op |=> !MEM_WE)
    else $error("memory written without an operation");

  // A flag load with no operation copies both flags in.
  a_flag_load_path: assert property (@(posedge MCLK) disable iff (SYS_RST)
    s_no_op ##0 FLAG_LOAD |=> CARRY_FLAG == $past(CARRY_IN)
      && HALF_CARRY_FLAG == $past(HALF_CARRY_IN))
    else $error("flag load not applied");

  // An accumulator load with no operation copies the byte in.
  a_acc_load_path: assert property (@(posedge MCLK) disable iff (SYS_RST)
    s_no_op ##0 ACC_LOAD |=> ACCUMULATOR_REG == $past(ACC_IN))
    else $error("accumulator load not applied");

  // A low enable holds the accumulator, write strobe and carry, whatever else the inputs ask for.
  a_freeze_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
    !CLK_EN |=> $stable(ACCUMULATOR_REG) && $stable(MEM_WE) && $stable(CARRY_FLAG))
    else $error("state moved while enable low");
endmodule
`default_nettype wire

// *** test/cda_alu_tb.sv ***
// Self-checking bench for the complement and decimal-adjust slice.
`timescale 1ns/1ps
`default_nettype none
module cda_alu_tb;
  import cda_alu_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic op_valid = 1'b0;
  cda_op_t op_sel = CDA_OP_NONE;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] acc_in = 8'h00;
  logic flag_load = 1'b0;
  logic half_in = 1'b0;
  logic carry_in = 1'b0;
  logic acc_load = 1'b0;
  logic [7:0] mem_wdata;
  logic [7:0] acc;
  logic mem_we, zero, carry, half;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] vals [4] = '{8'h00, 8'hFF, 8'h0F, 8'hA5};
  logic [7:0] da_a [7] = '{8'h45, 8'h4B, 8'h38, 8'hA2, 8'h12, 8'h9A, 8'h99};
  logic [6:0] da_c = 7'h50;
  logic [6:0] da_h = 7'h44;
  logic [8:0] e;

  cda_alu DUT (.MCLK(mclk), .SYS_RST(sys_rst), .CLK_EN(clk_en), .OP_VALID(op_valid),
    .OP_SEL(op_sel), .MEM_RDATA(mem_rdata), .FLAG_LOAD(flag_load), .HALF_CARRY_IN(half_in),
    .CARRY_IN(carry_in), .ACC_LOAD(acc_load), .ACC_IN(acc_in), .MEM_WE(mem_we),
    .MEM_WDATA(mem_wdata), .ACCUMULATOR_REG(acc), .ZERO_FLAG(zero), .CARRY_FLAG(carry),
    .HALF_CARRY_FLAG(half));

  // Free-running core clock, 25 ns period.
  always #12.5 mclk = ~mclk;

  // A hang is cut short well past the fewer than a hundred cycles the tests need.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Every drive lands 1 ns after a rising edge, clear of the sampling instant.
  task automatic step;
    @(posedge mclk);
    #1;
  endtask

  task automatic load(input logic [7:0] a, input logic c, input logic h);
    step();
    {acc_load, acc_in, flag_load, carry_in, half_in} = {1'b1, a, 1'b1, c, h};
    step();
    {acc_load, flag_load} = 2'b00;
  endtask

  task automatic op(input cda_op_t s, input logic [7:0] d);
    step();
    op_valid = 1'b1;
    op_sel = s;
    mem_rdata = d;
    step();
    op_valid = 1'b0;
    op_sel = CDA_OP_NONE;
  endtask

  // Reference result of the decimal correction, carry in bit 8; the high test sees the
  // nibble after the low correction, as a hand calculation would.
  function automatic logic [8:0] ref_adjust(input logic [7:0] a, input logic c, input logic h);
    logic [8:0] s;
    s = {1'b0, a} + ((a[3:0] > 4'h9 || h) ? 9'h006 : 9'h000);
    s = s + ((s[7:4] > 4'h9 || s[8] || c) ? 9'h060 : 9'h000);
    return {s[8] | c, s[7:0]};
  endfunction

  task automatic t_invert_mem;
    load(8'h5A, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      op(CDA_OP_COMPLEMENT_MEMORY, vals[i]);
      chk("we", mem_we, 8'h01);
      chk("wdata", mem_wdata, ~vals[i]);
      chk("zero", zero, vals[i] == 8'hFF);
      chk("acc", acc, 8'h5A);
    end
    step();
    chk("we_end", mem_we, 8'h00);
    $display("complement memory test done");
  endtask

  task automatic t_invert_acc;
    load(8'h33, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      op(CDA_OP_COMPLEMENT_TO_ACC, vals[i]);
      chk("acc", acc, ~vals[i]);
      chk("we", mem_we, 8'h00);
      chk("zero", zero, vals[i] == 8'hFF);
    end
    // A frozen enable must swallow the request entirely.
    clk_en = 1'b0;
    op(CDA_OP_COMPLEMENT_TO_ACC, 8'h00);
    chk("acc_frozen", acc, ~vals[3]);
    clk_en = 1'b1;
    $display("complement to accumulator test done");
  endtask

  task automatic t_adjust;
    op(CDA_OP_COMPLEMENT_MEMORY, 8'hFF);
    for (int i = 0; i < 7; i++) begin
      load(da_a[i], da_c[i], da_h[i]);
      op(CDA_OP_DECIMAL_ADJUST, 8'h00);
      e = ref_adjust(da_a[i], da_c[i], da_h[i]);
      chk("we", mem_we, 8'h01);
      chk("wdata", mem_wdata, e[7:0]);
      chk("carry", carry, e[8]);
      chk("zero", zero, 8'h01);
      chk("half", half, da_h[i]);
      chk("acc", acc, da_a[i]);
    end
    $display("decimal adjust test done");
  endtask

  // A mid-run reset must clear every output at once, without waiting for a clock.
  task automatic t_reset;
    op(CDA_OP_COMPLEMENT_MEMORY, 8'h0F);
    sys_rst = 1'b1;
    #1;
    chk("we_mid_rst", mem_we, 8'h00);
    chk("wdata_mid_rst", mem_wdata, 8'h00);
    chk("acc_mid_rst", acc, 8'h00);
    chk("flags_mid_rst", {5'h00, zero, carry, half}, 8'h00);
    step();
    sys_rst = 1'b0;
    op(CDA_OP_COMPLEMENT_TO_ACC, 8'hF0);
    chk("acc_after_rst", acc, 8'h0F);
    $display("reset test done");
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    chk("acc_rst", acc, 8'h00);
    chk("we_rst", mem_we, 8'h00);
    chk("wdata_rst", mem_wdata, 8'h00);
    chk("flags_rst", {5'h00, zero, carry, half}, 8'h00);
    t_invert_mem();
    t_invert_acc();
    t_adjust();
    t_reset();
    test_done();
  end
endmodule
`default_nettype wire
